// File: src/cal_cfg_pkg.sv
// Constants and register map for the calibration-mode configuration bank
// Functional notes
// [R1] Calibration uses stored reference voltage, default 12600
// [R2] Calibration uses stored reference temperature, default 298
// [R3] Counter offset time: floor to 250, error below
// [R4] Converter offset time: floor to 32, error below
// [R5] Current gain time: floor to 250, error below
// [R6] Voltage time: floor to 1984, error below
// [R7] Temperature time: floor to 32, error below
// [R8] Leave calibration after timeout, 1/128 s units
// [R9] Calibration uses stored reference current, default 3000
// [R10] Steps timed by millisecond tick from clock
package cal_cfg_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned TIMEOUT_DIV   = 128;
  localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_S;
  localparam int unsigned TICK128_CYCLES = CLK_HZ / TIMEOUT_DIV;
  localparam int unsigned ADDR_W        = 5;
  localparam int unsigned DATA_W        = 16;
  // Register offsets
  localparam logic [4:0] ADDR_REF_AMPS   = 5'h00;
  localparam logic [4:0] ADDR_REF_VOLT   = 5'h02;
  localparam logic [4:0] ADDR_REF_TEMP   = 5'h04;
  localparam logic [4:0] ADDR_CC_OFF_DUR = 5'h06;
  localparam logic [4:0] ADDR_ADC_OFF_DUR = 5'h08;
  localparam logic [4:0] ADDR_GAIN_DUR   = 5'h0A;
  localparam logic [4:0] ADDR_VOLT_DUR   = 5'h0C;
  localparam logic [4:0] ADDR_TEMP_DUR   = 5'h0E;
  localparam logic [4:0] ADDR_TIMEOUT    = 5'h11;
  localparam logic [4:0] ADDR_CONTROL    = 5'h14;
  localparam logic [4:0] ADDR_STATUS     = 5'h15;
  // Reset values
  localparam logic [15:0] RST_REF_AMPS   = 16'h0BB8;
  localparam logic [15:0] RST_REF_VOLT   = 16'h3138;
  localparam logic [15:0] RST_REF_TEMP   = 16'h012A;
  localparam logic [15:0] RST_CC_OFF_DUR = 16'h00FA;
  localparam logic [15:0] RST_ADC_OFF_DUR = 16'h0020;
  localparam logic [15:0] RST_GAIN_DUR   = 16'h00FA;
  localparam logic [15:0] RST_VOLT_DUR   = 16'h0760;
  localparam logic [15:0] RST_TEMP_DUR   = 16'h0020;
  localparam logic [15:0] RST_TIMEOUT    = 16'h9600;
  // Step quanta in ms
  localparam logic [15:0] QUANT_CC_OFF   = 16'h00FA;
  localparam logic [15:0] QUANT_ADC_OFF  = 16'h0020;
  localparam logic [15:0] QUANT_GAIN     = 16'h00FA;
  localparam logic [15:0] QUANT_VOLT     = 16'h07C0;
  localparam logic [15:0] QUANT_TEMP     = 16'h0020;
  // Control and status bit positions
  localparam int unsigned CTL_START_BIT  = 0;
  localparam int unsigned CTL_ABORT_BIT  = 1;
  localparam int unsigned ST_ACTIVE_BIT  = 0;
  localparam int unsigned ST_TIMEOUT_BIT = 1;
  localparam int unsigned ST_ERR_LSB     = 2;
  localparam int unsigned ST_STEP_LSB    = 8;
  localparam int unsigned NUM_STEPS      = 5;

  typedef enum logic [2:0] {
    STEP_CC_OFF,
    STEP_ADC_OFF,
    STEP_GAIN,
    STEP_VOLT,
    STEP_TEMP
  } step_t;
endpackage

// File: src/tick_divider.sv
// Clock divider producing a one-cycle enable pulse
`timescale 1ns/10ps
module tick_divider #(
  parameter int unsigned DIVIDE = 100_000
) (
  input  wire logic i_mclk,
  input  wire logic i_srst,
  input  wire logic i_clear,
  output logic      o_tick
);
  localparam int unsigned CW = $clog2(DIVIDE + 1);
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

  initial
  begin
    if (DIVIDE < 2) $error("tick_divider needs DIVIDE of at least 2");
  end

  typedef struct packed {
    logic [CW-1:0] count;
    logic          tick;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;

  // Count up through the period; clear restarts phase so steps start aligned
  always_comb
  begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (i_clear)
      next_st.count = '0;
    else if (st.count == LAST)
    begin
      next_st.count = '0;
      next_st.tick  = 1'b1;
    end
    else
      next_st.count = st.count + CW'(1);
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_tick = st.tick;

  a_tick_period: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_tick |=> !o_tick) else $error("tick lasted more than one cycle");
endmodule

// File: src/step_timer.sv
// Calibration step timer: rounds the duration down and counts ms ticks
`timescale 1ns/10ps
module step_timer (
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic        i_start,
  input  wire logic [15:0] i_duration,
  input  wire logic [15:0] i_quantum,
  input  wire logic        i_ms_tick,
  output logic             o_done,
  output logic             o_error,
  output logic [15:0]      o_rounded
);
  typedef struct packed {
    logic        busy;
    logic [15:0] remain;
    logic [15:0] rounded;
    logic        done;
    logic        error;
  } timer_state_t;

  timer_state_t st;
  timer_state_t next_st;
  logic [15:0]  floor_val;

  // Floor to a whole number of quanta; modulo is costly but runs once per step
  assign floor_val = i_duration - (i_duration % i_quantum);

  always_comb
  begin
    next_st       = st;
    next_st.done  = 1'b0;
    next_st.error = 1'b0;
    if (i_start)
    begin
      next_st.rounded = floor_val;
      if (i_duration < i_quantum)
        next_st.error = 1'b1;                    // [R3] [R4] [R5] [R6] [R7]
      else
      begin
        next_st.busy   = 1'b1;
        next_st.remain = floor_val;              // [R3] [R4] [R5] [R6] [R7]
      end
    end
    else if (st.busy && i_ms_tick)
    begin
      next_st.remain = st.remain - 16'h0001;     // [R10]
      if (st.remain == 16'h0001)
      begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_done    = st.done;
  assign o_error   = st.error;
  assign o_rounded = st.rounded;

  a_short_error: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_start && (i_duration < i_quantum) |=> o_error) // [R3]
    else $error("short duration gave no error");
  a_rounded_floor: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_start |=> (o_rounded % $past(i_quantum)) == 16'h0000) // [R4]
    else $error("duration not rounded to quantum");
endmodule

// File: src/cal_mode_config.sv
// Calibration-mode configuration registers and calibration sequencer
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
module cal_mode_config #(
  parameter int unsigned MS_CYCLES      = cal_cfg_pkg::MS_CYCLES,
  parameter int unsigned TICK128_CYCLES = cal_cfg_pkg::TICK128_CYCLES
) (
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic [4:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [15:0]      o_rdata,
  output logic             o_cal_active,
  output logic [2:0]       o_cal_step,
  output logic [15:0]      o_ref_volt,
  output logic [15:0]      o_ref_temp,
  output logic [15:0]      o_ref_amps
);
  initial
  begin
    if (MS_CYCLES < 2 || TICK128_CYCLES < 2)
      $error("cal_mode_config divider counts must be at least 2");
    // A zero quantum would make the floor arithmetic divide by zero
    if (cal_cfg_pkg::QUANT_CC_OFF == 16'h0000 || cal_cfg_pkg::QUANT_ADC_OFF == 16'h0000
        || cal_cfg_pkg::QUANT_GAIN == 16'h0000 || cal_cfg_pkg::QUANT_VOLT == 16'h0000
        || cal_cfg_pkg::QUANT_TEMP == 16'h0000)
      $error("cal_mode_config step quanta must be nonzero");
  end

  typedef enum logic [1:0] {
    IDLE,
    LAUNCH,
    RUN
  } seq_t;

  typedef struct packed {
    logic [15:0]       ref_amps;
    logic [15:0]       ref_volt;
    logic [15:0]       ref_temp;
    logic [15:0]       dur_cc;
    logic [15:0]       dur_adc;
    logic [15:0]       dur_gain;
    logic [15:0]       dur_volt;
    logic [15:0]       dur_temp;
    logic [15:0]       timeout;
    logic [15:0]       rdata;
    seq_t              seq;
    cal_cfg_pkg::step_t step;
    logic [15:0]       elapsed;
    logic [4:0]        err;
    logic              timed_out;
    logic [15:0]       out_volt;    // Reference outputs, zero while idle
    logic [15:0]       out_temp;
    logic [15:0]       out_amps;
  } cfg_state_t;

  cfg_state_t  st;
  cfg_state_t  next_st;
  logic        ms_tick;
  logic        t128_tick;
  logic        step_start;
  logic        step_done;
  logic        step_err;
  logic [15:0] step_dur;
  logic [15:0] step_quant;
  logic [15:0] status_word;
  logic        start_req;
  logic        abort_req;

  // Duration and quantum of the step in progress
  function automatic logic [15:0] dur_of(input cfg_state_t s);
    case (s.step)
      cal_cfg_pkg::STEP_CC_OFF:  dur_of = s.dur_cc;
      cal_cfg_pkg::STEP_ADC_OFF: dur_of = s.dur_adc;
      cal_cfg_pkg::STEP_GAIN:    dur_of = s.dur_gain;
      cal_cfg_pkg::STEP_VOLT:    dur_of = s.dur_volt;
      default:                   dur_of = s.dur_temp;
    endcase
  endfunction

  function automatic logic [15:0] quant_of(input cal_cfg_pkg::step_t s);
    case (s)
      cal_cfg_pkg::STEP_CC_OFF:  quant_of = cal_cfg_pkg::QUANT_CC_OFF;
      cal_cfg_pkg::STEP_ADC_OFF: quant_of = cal_cfg_pkg::QUANT_ADC_OFF;
      cal_cfg_pkg::STEP_GAIN:    quant_of = cal_cfg_pkg::QUANT_GAIN;
      cal_cfg_pkg::STEP_VOLT:    quant_of = cal_cfg_pkg::QUANT_VOLT;
      default:                   quant_of = cal_cfg_pkg::QUANT_TEMP;
    endcase
  endfunction

  // Control write carrying one command bit; start and abort share this decode
  function automatic logic ctl_hit(input logic wr, input logic [4:0] addr,
                                   input logic [15:0] wdata, input int unsigned pos);
    ctl_hit = wr && (addr == cal_cfg_pkg::ADDR_CONTROL) && wdata[pos];
  endfunction

  assign step_dur   = dur_of(st);
  assign step_quant = quant_of(st.step);
  assign step_start = (st.seq == LAUNCH);
  assign start_req  = ctl_hit(i_wr, i_addr, i_wdata, cal_cfg_pkg::CTL_START_BIT);
  assign abort_req  = ctl_hit(i_wr, i_addr, i_wdata, cal_cfg_pkg::CTL_ABORT_BIT);

  tick_divider #(
    .DIVIDE (MS_CYCLES)
  ) u_ms_div (
    .i_mclk  (i_mclk),
    .i_srst  (i_srst),
    .i_clear (step_start),
    .o_tick  (ms_tick)
  );

  // Separate divider so the timeout counts true 1/128 s units
  tick_divider #(
    .DIVIDE (TICK128_CYCLES)
  ) u_t128_div (
    .i_mclk  (i_mclk),
    .i_srst  (i_srst),
    .i_clear (st.seq == IDLE),
    .o_tick  (t128_tick)
  );

  step_timer u_step (
    .i_mclk     (i_mclk),
    .i_srst     (i_srst),
    .i_start    (step_start),
    .i_duration (step_dur),
    .i_quantum  (step_quant),
    .i_ms_tick  (ms_tick),
    .o_done     (step_done),
    .o_error    (step_err),
    .o_rounded  ()
  );

  // Status layout: active, timeout, per-step errors, current step
  always_comb
  begin
    status_word = '0;
    status_word[cal_cfg_pkg::ST_ACTIVE_BIT] = (st.seq != IDLE);
    status_word[cal_cfg_pkg::ST_TIMEOUT_BIT] = st.timed_out;
    status_word[cal_cfg_pkg::ST_ERR_LSB +: 5] = st.err;
    status_word[cal_cfg_pkg::ST_STEP_LSB +: 3] = st.step;
  end

  // Register writes, reads and the step sequencer
  always_comb
  begin
    next_st = st;
    if (i_wr)
    begin
      case (i_addr)
        cal_cfg_pkg::ADDR_REF_AMPS:    next_st.ref_amps = i_wdata;
        cal_cfg_pkg::ADDR_REF_VOLT:    next_st.ref_volt = i_wdata;
        cal_cfg_pkg::ADDR_REF_TEMP:    next_st.ref_temp = i_wdata;
        cal_cfg_pkg::ADDR_CC_OFF_DUR:  next_st.dur_cc   = i_wdata;
        cal_cfg_pkg::ADDR_ADC_OFF_DUR: next_st.dur_adc  = i_wdata;
        cal_cfg_pkg::ADDR_GAIN_DUR:    next_st.dur_gain = i_wdata;
        cal_cfg_pkg::ADDR_VOLT_DUR:    next_st.dur_volt = i_wdata;
        cal_cfg_pkg::ADDR_TEMP_DUR:    next_st.dur_temp = i_wdata;
        cal_cfg_pkg::ADDR_TIMEOUT:     next_st.timeout  = i_wdata;
        default: ;
      endcase
    end
    if (i_rd)
    begin
      case (i_addr)
        cal_cfg_pkg::ADDR_REF_AMPS:    next_st.rdata = st.ref_amps;
        cal_cfg_pkg::ADDR_REF_VOLT:    next_st.rdata = st.ref_volt;
        cal_cfg_pkg::ADDR_REF_TEMP:    next_st.rdata = st.ref_temp;
        cal_cfg_pkg::ADDR_CC_OFF_DUR:  next_st.rdata = st.dur_cc;
        cal_cfg_pkg::ADDR_ADC_OFF_DUR: next_st.rdata = st.dur_adc;
        cal_cfg_pkg::ADDR_GAIN_DUR:    next_st.rdata = st.dur_gain;
        cal_cfg_pkg::ADDR_VOLT_DUR:    next_st.rdata = st.dur_volt;
        cal_cfg_pkg::ADDR_TEMP_DUR:    next_st.rdata = st.dur_temp;
        cal_cfg_pkg::ADDR_TIMEOUT:     next_st.rdata = st.timeout;
        cal_cfg_pkg::ADDR_STATUS:      next_st.rdata = status_word;
        default:                       next_st.rdata = 16'h0000;
      endcase
    end

    // Elapsed time runs through launch cycles too, so no tick is lost
    if (st.seq != IDLE && t128_tick)
      next_st.elapsed = st.elapsed + 16'h0001;    // [R8]

    case (st.seq)
      IDLE:
      begin
        if (start_req)
        begin
          next_st.seq       = LAUNCH;
          next_st.step      = cal_cfg_pkg::STEP_CC_OFF;
          next_st.elapsed   = '0;
          next_st.err       = '0;
          next_st.timed_out = 1'b0;
        end
      end
      LAUNCH:
        next_st.seq = RUN;
      RUN:
      begin
        if (step_err)
          next_st.err[st.step] = 1'b1;            // [R3] [R6]
        if (step_done || step_err)
        begin
          if (st.step == cal_cfg_pkg::STEP_TEMP)
            next_st.seq = IDLE;
          else
          begin
            next_st.step = cal_cfg_pkg::step_t'(st.step + 3'h1);
            next_st.seq  = LAUNCH;
          end
        end
      end
      default:
        next_st.seq = IDLE;
    endcase

    // Timeout and abort override the step flow
    if (st.seq != IDLE && st.elapsed >= st.timeout)
    begin
      next_st.seq       = IDLE;                   // [R8]
      next_st.timed_out = 1'b1;
    end
    if (st.seq != IDLE && abort_req)
      next_st.seq = IDLE;

    // References leave flip-flops; they follow the mode of the coming cycle
    next_st.out_volt = (next_st.seq != IDLE) ? next_st.ref_volt : 16'h0000;  // [R1]
    next_st.out_temp = (next_st.seq != IDLE) ? next_st.ref_temp : 16'h0000;  // [R2]
    next_st.out_amps = (next_st.seq != IDLE) ? next_st.ref_amps : 16'h0000;  // [R9]
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      st          <= '0;
      st.ref_amps <= cal_cfg_pkg::RST_REF_AMPS;   // [R9]
      st.ref_volt <= cal_cfg_pkg::RST_REF_VOLT;   // [R1]
      st.ref_temp <= cal_cfg_pkg::RST_REF_TEMP;   // [R2]
      st.dur_cc   <= cal_cfg_pkg::RST_CC_OFF_DUR;
      st.dur_adc  <= cal_cfg_pkg::RST_ADC_OFF_DUR;
      st.dur_gain <= cal_cfg_pkg::RST_GAIN_DUR;
      st.dur_volt <= cal_cfg_pkg::RST_VOLT_DUR;
      st.dur_temp <= cal_cfg_pkg::RST_TEMP_DUR;
      st.timeout  <= cal_cfg_pkg::RST_TIMEOUT;
      st.seq      <= IDLE;
      st.step     <= cal_cfg_pkg::STEP_CC_OFF;
    end
    else
      st <= next_st;
  end

  // References are only presented while calibration runs
  assign o_rdata      = st.rdata;
  assign o_cal_active = (st.seq != IDLE);
  assign o_cal_step   = st.step;
  assign o_ref_volt   = st.out_volt;                            // [R1]
  assign o_ref_temp   = st.out_temp;                            // [R2]
  assign o_ref_amps   = st.out_amps;                            // [R9]

  a_timeout_exit: assert property (@(posedge i_mclk) disable iff (i_srst) // [R8]
    (st.seq != IDLE && st.elapsed >= st.timeout) |=> !o_cal_active)
    else $error("calibration outlived its timeout");
  a_ref_volt: assert property (@(posedge i_mclk) disable iff (i_srst) // [R1]
    o_cal_active |-> o_ref_volt == st.ref_volt)
    else $error("reference voltage not presented");
  a_ref_temp: assert property (@(posedge i_mclk) disable iff (i_srst) // [R2]
    o_cal_active |-> o_ref_temp == st.ref_temp)
    else $error("reference temperature not presented");
  a_ref_amps: assert property (@(posedge i_mclk) disable iff (i_srst) // [R9]
    o_cal_active |-> o_ref_amps == st.ref_amps)
    else $error("reference current not presented");
  a_error_flag: assert property (@(posedge i_mclk) disable iff (i_srst) // [R5]
    (st.seq == RUN && step_err && !i_wr) |=> st.err[$past(st.step)])
    else $error("step error not recorded");
  a_step_tick: assert property (@(posedge i_mclk) disable iff (i_srst) // [R10]
    step_done |-> $past(ms_tick))
    else $error("step ended off a millisecond tick");
  a_err_no_wait: assert property (@(posedge i_mclk) disable iff (i_srst) // [R7]
    step_start && (step_dur < step_quant) |=> step_err)
    else $error("short step not flagged at once");

  // Each step is held against its own register and quantum, not the shared mux
  a_cc_short: assert property (@(posedge i_mclk) disable iff (i_srst) // [R3]
    step_start && st.step == cal_cfg_pkg::STEP_CC_OFF
      && st.dur_cc < cal_cfg_pkg::QUANT_CC_OFF |=> step_err)
    else $error("short counter offset time not flagged");
  a_adc_short: assert property (@(posedge i_mclk) disable iff (i_srst) // [R4]
    step_start && st.step == cal_cfg_pkg::STEP_ADC_OFF
      && st.dur_adc < cal_cfg_pkg::QUANT_ADC_OFF |=> step_err)
    else $error("short converter offset time not flagged");
  a_gain_short: assert property (@(posedge i_mclk) disable iff (i_srst) // [R5]
    step_start && st.step == cal_cfg_pkg::STEP_GAIN
      && st.dur_gain < cal_cfg_pkg::QUANT_GAIN |=> step_err)
    else $error("short current gain time not flagged");
  a_volt_short: assert property (@(posedge i_mclk) disable iff (i_srst) // [R6]
    step_start && st.step == cal_cfg_pkg::STEP_VOLT
      && st.dur_volt < cal_cfg_pkg::QUANT_VOLT |=> step_err)
    else $error("short voltage time not flagged");
  a_temp_short: assert property (@(posedge i_mclk) disable iff (i_srst) // [R7]
    step_start && st.step == cal_cfg_pkg::STEP_TEMP
      && st.dur_temp < cal_cfg_pkg::QUANT_TEMP |=> step_err)
    else $error("short temperature time not flagged");

  // Mode entry, exit and step sequencing
  a_start_clears: assert property (@(posedge i_mclk) disable iff (i_srst) // [R8]
    $rose(o_cal_active) |-> st.err == 5'h00 && !st.timed_out && st.elapsed == 16'h0000
      && o_cal_step == 3'h0)
    else $error("new run did not start clean");
  a_abort_exit: assert property (@(posedge i_mclk) disable iff (i_srst) // [R8]
    o_cal_active && abort_req |=> !o_cal_active)
    else $error("abort left calibration running");
  a_timeout_flag: assert property (@(posedge i_mclk) disable iff (i_srst) // [R8]
    $rose(st.timed_out) |-> !o_cal_active)
    else $error("timeout flag raised while still active");
  a_step_order: assert property (@(posedge i_mclk) disable iff (i_srst) // [R10]
    st.seq == RUN && (step_done || step_err) && st.step != cal_cfg_pkg::STEP_TEMP
      |=> o_cal_step == $past(o_cal_step) + 3'h1)
    else $error("steps did not advance one at a time");
  a_errors_kept: assert property (@(posedge i_mclk) disable iff (i_srst) // [R5]
    o_cal_active |=> (st.err & $past(st.err)) == $past(st.err))
    else $error("step error flag lost during a run");
  a_refs_idle: assert property (@(posedge i_mclk) disable iff (i_srst) // [R9]
    !o_cal_active |-> (o_ref_volt | o_ref_temp | o_ref_amps) == 16'h0000)
    else $error("reference shown outside calibration");

  // Main scenarios: start, timeout, short step, full step, abort
  c_start: cover property (@(posedge i_mclk) $rose(o_cal_active));
  c_timeout: cover property (@(posedge i_mclk) $rose(st.timed_out));
  c_step_err: cover property (@(posedge i_mclk) step_err);
  c_step_done: cover property (@(posedge i_mclk) step_done);
  c_abort: cover property (@(posedge i_mclk) o_cal_active && abort_req);
endmodule

// File: test/cal_host_model.sv
// Host controller model that drives the register port of the configuration bank
`timescale 1ns/10ps
module cal_host_model (
  input  wire logic        i_mclk,
  input  wire logic [15:0] i_rdata,
  output logic [4:0]       o_addr,
  output logic [15:0]      o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  initial
  begin
    o_addr = 5'h00;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // One-cycle write strobe; the bank never stalls the host
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_wdata <= ~d; // Stale data must not be mistaken for a held bus
  endtask

  // Read data appears in the cycle after the strobe and holds until the next read, so sample it there
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule

// File: test/calibration_mode_config_tb.sv
// Self-checking testbench for the calibration-mode configuration bank
`timescale 1ns/10ps
module calibration_mode_config_tb;
  localparam int MS = 10;
  localparam int T128 = 20;
  logic        mclk;
  logic        srst;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        cal_active;
  logic [2:0]  cal_step;
  logic [15:0] ref_volt;
  logic [15:0] ref_temp;
  logic [15:0] ref_amps;
  int          n_fail;
  int          checked;

  cal_mode_config #(.MS_CYCLES(MS), .TICK128_CYCLES(T128)) DUT (
    .i_mclk(mclk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_cal_active(cal_active), .o_cal_step(cal_step),
    .o_ref_volt(ref_volt), .o_ref_temp(ref_temp), .o_ref_amps(ref_amps)
  );

  cal_host_model host (
    .i_mclk(mclk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd)
  );

  // Free-running 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_reg(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.rd_reg(a, d);
    chk($sformatf("reg %h", a), exp, d);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Start a run and count cycles until it ends; steps must advance one at a time
  task automatic run_cal(output int cycles);
    logic [2:0] prev;
    host.wr_reg(cal_cfg_pkg::ADDR_CONTROL, 16'h0001);
    #1;
    chk("active after start", 16'h0001, {15'h0000, cal_active});
    prev = 3'h0;
    cycles = 0;
    while (cal_active === 1'b1 && cycles < 40000)
    begin
      @(posedge mclk);
      #1;
      cycles++;
      if (cal_step !== prev)
      begin
        chk("step order", {13'h0000, prev + 3'h1}, {13'h0000, cal_step});
        prev = cal_step;
      end
    end
    chk("run ended", 16'h0000, {15'h0000, cal_active});
  endtask

  task automatic t_reset_values();
    chk_reg(cal_cfg_pkg::ADDR_REF_VOLT, 16'h3138);
    chk_reg(cal_cfg_pkg::ADDR_REF_TEMP, 16'h012A);
    chk_reg(cal_cfg_pkg::ADDR_CC_OFF_DUR, 16'h00FA);
    chk_reg(cal_cfg_pkg::ADDR_ADC_OFF_DUR, 16'h0020);
    chk_reg(cal_cfg_pkg::ADDR_GAIN_DUR, 16'h00FA);
    chk_reg(cal_cfg_pkg::ADDR_VOLT_DUR, 16'h0760);
    chk_reg(cal_cfg_pkg::ADDR_TEMP_DUR, 16'h0020);
    chk_reg(cal_cfg_pkg::ADDR_TIMEOUT, 16'h9600);
    chk_reg(cal_cfg_pkg::ADDR_REF_AMPS, 16'h0BB8);
    chk_reg(5'h1F, 16'h0000);
  endtask

  // References reach the outputs only while calibrating; abort ends the run
  task automatic t_refs();
    host.wr_reg(cal_cfg_pkg::ADDR_REF_VOLT, 16'h7FFF);
    host.wr_reg(cal_cfg_pkg::ADDR_REF_TEMP, 16'h0BA5);
    host.wr_reg(cal_cfg_pkg::ADDR_REF_AMPS, 16'h1234);
    #1;
    chk("idle volt", 16'h0000, ref_volt);
    host.wr_reg(cal_cfg_pkg::ADDR_CONTROL, 16'h0001);
    #1;
    chk("ref volt", 16'h7FFF, ref_volt);
    chk("ref temp", 16'h0BA5, ref_temp);
    chk("ref amps", 16'h1234, ref_amps);
    host.wr_reg(cal_cfg_pkg::ADDR_CONTROL, 16'h0002);
    @(posedge mclk);
    #1;
    chk("aborted", 16'h0000, {15'h0000, cal_active});
    chk("idle amps", 16'h0000, ref_amps);
  endtask

  // Durations just under, at, or (counter offset and voltage) well over each quantum; the default voltage time errs
  task automatic t_durations();
    int cyc;
    run_cal(cyc);
    chk_reg(cal_cfg_pkg::ADDR_STATUS, 16'h0420);
    host.wr_reg(cal_cfg_pkg::ADDR_TIMEOUT, 16'hFFFF);
    host.wr_reg(cal_cfg_pkg::ADDR_CC_OFF_DUR, 16'h00F9);
    host.wr_reg(cal_cfg_pkg::ADDR_ADC_OFF_DUR, 16'h0020);
    host.wr_reg(cal_cfg_pkg::ADDR_GAIN_DUR, 16'h00F9);
    host.wr_reg(cal_cfg_pkg::ADDR_VOLT_DUR, 16'h07BF);
    host.wr_reg(cal_cfg_pkg::ADDR_TEMP_DUR, 16'h0020);
    run_cal(cyc);
    chk_reg(cal_cfg_pkg::ADDR_STATUS, 16'h0434);
    host.wr_reg(cal_cfg_pkg::ADDR_CC_OFF_DUR, 16'h01F3);
    host.wr_reg(cal_cfg_pkg::ADDR_ADC_OFF_DUR, 16'h001F);
    host.wr_reg(cal_cfg_pkg::ADDR_GAIN_DUR, 16'h00FA);
    host.wr_reg(cal_cfg_pkg::ADDR_VOLT_DUR, 16'h0F7F);
    host.wr_reg(cal_cfg_pkg::ADDR_TEMP_DUR, 16'h001F);
    run_cal(cyc);
    chk_reg(cal_cfg_pkg::ADDR_STATUS, 16'h0448);
    // 250 + 250 + 1984 ms after rounding down, plus a few launch cycles per step
    if (cyc < 2484 * MS || cyc > 2484 * MS + 80)
      chk("rounded run length", 16'h0001, 16'h0000);
    else
      chk("rounded run length", 16'h0001, 16'h0001);
  endtask

  // A short timeout cuts a long run and raises the timeout flag
  task automatic t_timeout();
    int cyc;
    host.wr_reg(cal_cfg_pkg::ADDR_TIMEOUT, 16'h000A);
    run_cal(cyc);
    if (cyc < 10 * T128 - 5 || cyc > 10 * T128 + 30)
      chk("timeout length", 16'h0001, 16'h0000);
    else
      chk("timeout length", 16'h0001, 16'h0001);
    chk_reg(cal_cfg_pkg::ADDR_STATUS, 16'h0002);
  endtask

  // Reset in mid-run drops calibration mode and restores the defaults
  task automatic t_mid_reset();
    host.wr_reg(cal_cfg_pkg::ADDR_CONTROL, 16'h0001);
    repeat (3) @(posedge mclk);
    srst <= 1'b1;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    #1;
    chk("reset active", 16'h0000, {15'h0000, cal_active});
    chk("reset amps out", 16'h0000, ref_amps);
    chk_reg(cal_cfg_pkg::ADDR_TIMEOUT, 16'h9600);
    chk_reg(cal_cfg_pkg::ADDR_REF_AMPS, 16'h0BB8);
  endtask

  // Watchdog sized well above the roughly 32k cycles the scenarios need
  initial
  begin
    #500_000;
    n_fail++;
    finish_test();
  end

  initial
  begin
    n_fail = 0;
    checked = 0;
    srst = 1'b1;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    t_reset_values();
    t_refs();
    t_durations();
    t_timeout();
    t_mid_reset();
    finish_test();
  end
endmodule
